/* logic/tss_params.svh */
`ifndef TSS_PARAMS_SVH
`define TSS_PARAMS_SVH

// clock period and the microsecond timebase derived from it
`define TSS_CLK_PERIOD_NS 5
`define TSS_US_NS 1000
`define TSS_CYC_PER_US ((`TSS_US_NS + `TSS_CLK_PERIOD_NS - 1) / `TSS_CLK_PERIOD_NS)

// control task length in microseconds
`define TSS_TASK_US 10'h3E8

// source selector codes
`define TSS_SEL_AUTO 7'h00
`define TSS_SEL_CAN 7'h01
`define TSS_SEL_SYS 7'h02
`define TSS_SEL_OFF 7'h63
`define TSS_SEL_RST `TSS_SEL_CAN

// phase offset limits and reset value in microseconds
`define TSS_OFS_MIN_US 10'h2BC
`define TSS_OFS_MAX_US 10'h384
`define TSS_OFS_RST_US 10'h320

// lock window, missed-sync margin and node number meaning "unset"
`define TSS_LOCK_TOL_US 10'h00A
`define TSS_MISS_MARGIN_US 16'h0064
`define TSS_NODE_NONE 7'h00

// control word fault reset bit
`define TSS_FR_CW_BIT 7

`endif

/* logic/tss_pkg.sv */
package tss_pkg;

    // source in effect; gray along none -> can -> sys
    typedef enum logic [1:0] {
        TSS_SRC_NONE = 2'b00,
        TSS_SRC_CAN  = 2'b01,
        TSS_SRC_SYS  = 2'b11
    } tss_src_e;

    // secondary bus synchronization setting
    typedef enum logic [1:0] {
        TSS_SYS_OFF   = 2'b00,
        TSS_SYS_SYNC  = 2'b01,
        TSS_SYS_RXPDO = 2'b10
    } tss_sysmode_e;

    typedef struct packed {
        logic [6:0] sel;
        logic [9:0] ofs;
    } tss_cfg_s;

    typedef struct packed {
        logic [15:0] period_us;
        logic [9:0]  pos_us;
        logic        lock;
    } tss_meas_s;

    typedef struct packed {
        logic statemachine;
        logic key_allowed;
        logic din_allowed;
        logic din_hw;
    } tss_fperm_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } tss_div_s;

    typedef struct packed {
        logic [15:0] elapsed;
        logic [15:0] period;
        logic [9:0]  pos;
        logic        seen;
        logic        lock;
    } tss_mon_s;

    typedef struct packed {
        tss_cfg_s    cfg;
        tss_src_e    src;
        logic [9:0]  task_us;
        logic [1:0]  adj;
        logic        task_tick;
        logic        cw_prev;
        logic        key_prev;
        logic        din_prev;
        logic        fault_reset;
        logic [63:0] pdo_hold;
        logic        pdo_pend;
        logic [63:0] pdo_app;
        logic        pdo_upd;
    } tss_top_s;

endpackage : tss_pkg

/* logic/tss_tick_div.sv */
`include "tss_params.svh"

module tss_tick_div #(
    parameter int DIV = `TSS_CYC_PER_US
) (
    input  wire logic core_clk_in,
    input  wire logic srst_in,
    output logic      tick_out
);
    import tss_pkg::*;

    tss_div_s state_reg;
    tss_div_s state_next;

    // free-running divider, one-cycle pulse per wrap
    always_comb
    begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.cnt == 8'(DIV - 1))
        begin
            state_next.cnt  = 8'h00;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.cnt = state_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign tick_out = state_reg.tick;

endmodule : tss_tick_div

/* logic/tss_sync_monitor.sv */
`include "tss_params.svh"

module tss_sync_monitor (
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    input  wire logic              us_tick_in,
    input  wire logic              event_in,
    input  wire logic              selected_in,
    input  wire logic [9:0]        task_pos_in,
    input  wire logic [9:0]        offset_in,
    output tss_pkg::tss_meas_s     meas_out
);
    import tss_pkg::*;

    tss_mon_s    state_reg;
    tss_mon_s    state_next;
    logic [16:0] limit;
    logic        missed;
    logic [9:0]  dev;

    // sync is overdue once the last period plus margin has gone by
    assign limit  = {1'b0, state_reg.period} + {1'b0, `TSS_MISS_MARGIN_US};
    assign missed = state_reg.seen && ({1'b0, state_reg.elapsed} > limit);
    assign dev    = (task_pos_in > offset_in) ? task_pos_in - offset_in : offset_in - task_pos_in;

    always_comb
    begin
        state_next = state_reg;
        if (event_in)
        begin
            state_next.period  = state_reg.elapsed;
            state_next.elapsed = 16'h0000;
            state_next.pos     = task_pos_in;
            state_next.seen    = 1'b1;
        end
        else if (us_tick_in && state_reg.elapsed != 16'hFFFF)
        begin
            state_next.elapsed = state_reg.elapsed + 16'h0001;
        end
        if (!selected_in || missed)
            state_next.lock = 1'b0;
        else if (event_in)
            state_next.lock = state_reg.seen && (dev <= `TSS_LOCK_TOL_US);
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign meas_out = '{period_us: state_reg.period, pos_us: state_reg.pos, lock: state_reg.lock};

endmodule : tss_sync_monitor

/* logic/tss_task_sync.sv */
// Function
// - selector codes 0 auto, 2 secondary, 99 off
// - code 1 selects CANopen, reset default
// - auto prefers CANopen, then secondary, else none
// - CANopen active: node above 0, sync PDO
// - secondary active: node above 0, SYNC/RxPDO
// - phase offset 700..900 us, default 800
// - track up to one per mille drift
// - steer task so sync hits offset
// - CANopen sync switchable on and off under auto selection
// - secondary accepts SYNC or RxPDO reference
// - readback of source in effect
// - per-source lock flag, 1 when locked
// - measure sync period in microseconds
// - report sync position within task
// - control word bit 7 fault reset
// - keypad stop resets only when permitted
// - input reset needs permission or hardware
// - hold RxPDO data until SYNC arrives
`include "tss_params.svh"

module tss_task_sync (
    input  wire logic                 core_clk_in,
    input  wire logic                 srst_in,
    // configuration load
    input  wire logic                 cfg_load_in,
    input  wire tss_pkg::tss_cfg_s    cfg_in,
    // CANopen side
    input  wire logic [6:0]           can_node_num_in,
    input  wire logic                 can_sync_pdo_run_in,
    input  wire logic                 can_sync_in,
    input  wire logic                 can_rxpdo_valid_in,
    input  wire logic [63:0]          can_rxpdo_data_in,
    // secondary drive bus side
    input  wire logic [6:0]           sys_node_id_in,
    input  wire tss_pkg::tss_sysmode_e sys_sync_mode_in,
    input  wire logic                 sys_sync_in,
    input  wire logic                 sys_rxpdo_in,
    // fault reset sources
    input  wire logic [15:0]          control_word_in,
    input  wire tss_pkg::tss_fperm_s  fault_perm_in,
    input  wire logic                 key_stop_in,
    input  wire logic                 din_reset_in,
    // readbacks
    output tss_pkg::tss_cfg_s         cfg_out,
    output tss_pkg::tss_src_e         sync_source_in_use_out,
    output logic                      can_active_out,
    output logic                      sys_active_out,
    output tss_pkg::tss_meas_s        can_meas_out,
    output tss_pkg::tss_meas_s        sys_meas_out,
    output logic                      task_tick_out,
    output logic [9:0]                task_pos_us_out,
    output logic [63:0]               app_data_out,
    output logic                      app_update_out,
    output logic                      fault_reset_out
);
    import tss_pkg::*;

    // adjustment codes for the next task length
    localparam logic [1:0] ADJ_NONE  = 2'b00;
    localparam logic [1:0] ADJ_LONG  = 2'b01;
    localparam logic [1:0] ADJ_SHORT = 2'b10;

    tss_top_s   state_reg;
    tss_top_s   state_next;
    logic       us_tick;
    logic       can_act;
    logic       sys_act;
    logic       sys_evt;
    logic       sel_evt;
    tss_src_e   src_pick;
    logic [9:0] task_end;
    logic       sel_ok;
    logic [9:0] ofs_clamp;
    logic       cw_bit;
    logic       cw_rise;
    logic       key_rise;
    logic       din_rise;
    tss_meas_s  can_meas;
    tss_meas_s  sys_meas;

    // microsecond timebase for task counter and period measurement
    tss_tick_div #(
        .DIV (`TSS_CYC_PER_US)
    ) u_us_div (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .tick_out    (us_tick)
    );

    assign can_act = (can_node_num_in != `TSS_NODE_NONE) && can_sync_pdo_run_in;

    assign sys_act = (sys_node_id_in != `TSS_NODE_NONE)
                  && ((sys_sync_mode_in == TSS_SYS_SYNC) || (sys_sync_mode_in == TSS_SYS_RXPDO));

    assign sys_evt = ((sys_sync_mode_in == TSS_SYS_SYNC) && sys_sync_in)
                  || ((sys_sync_mode_in == TSS_SYS_RXPDO) && sys_rxpdo_in);

    // source choice; unknown codes fall back to no sync
    always_comb
    begin
        case (state_reg.cfg.sel)
            `TSS_SEL_AUTO:
            begin
                if (can_act)
                    src_pick = TSS_SRC_CAN;
                else if (sys_act)
                    src_pick = TSS_SRC_SYS;
                else
                    src_pick = TSS_SRC_NONE;
            end
            `TSS_SEL_CAN:
                src_pick = TSS_SRC_CAN;
            `TSS_SEL_SYS:
                src_pick = TSS_SRC_SYS;
            default:
                src_pick = TSS_SRC_NONE;
        endcase
    end

    // sync event of whichever source is in effect
    always_comb
    begin
        case (state_reg.src)
            TSS_SRC_CAN:
                sel_evt = can_sync_in;
            TSS_SRC_SYS:
                sel_evt = sys_evt;
            default:
                sel_evt = 1'b0;
        endcase
    end

    // only documented selector codes are taken
    assign sel_ok = (cfg_in.sel == `TSS_SEL_AUTO) || (cfg_in.sel == `TSS_SEL_CAN)
                 || (cfg_in.sel == `TSS_SEL_SYS) || (cfg_in.sel == `TSS_SEL_OFF);

    // offset held inside its legal range
    always_comb
    begin
        if (cfg_in.ofs < `TSS_OFS_MIN_US)
            ofs_clamp = `TSS_OFS_MIN_US;
        else if (cfg_in.ofs > `TSS_OFS_MAX_US)
            ofs_clamp = `TSS_OFS_MAX_US;
        else
            ofs_clamp = cfg_in.ofs;
    end

    // one microsecond per task is exactly one per mille of slew
    always_comb
    begin
        if (state_reg.adj == ADJ_LONG)
            task_end = `TSS_TASK_US;
        else if (state_reg.adj == ADJ_SHORT)
            task_end = `TSS_TASK_US - 10'h002;
        else
            task_end = `TSS_TASK_US - 10'h001;
    end

    // fault reset edges; levels are held by software or switches
    assign cw_bit   = control_word_in[`TSS_FR_CW_BIT];
    assign cw_rise  = cw_bit && !state_reg.cw_prev;
    assign key_rise = key_stop_in && !state_reg.key_prev;
    assign din_rise = din_reset_in && !state_reg.din_prev;

    // next-state logic for the whole block
    always_comb
    begin
        state_next             = state_reg;
        state_next.task_tick   = 1'b0;
        state_next.pdo_upd     = 1'b0;
        state_next.fault_reset = 1'b0;
        state_next.cw_prev     = cw_bit;
        state_next.key_prev    = key_stop_in;
        state_next.din_prev    = din_reset_in;

        // configuration load; bad selector codes keep the old value
        if (cfg_load_in)
        begin
            if (sel_ok)
                state_next.cfg.sel = cfg_in.sel;
            state_next.cfg.ofs = ofs_clamp;
        end

        state_next.src = src_pick;

        // task counter, one step per microsecond
        if (us_tick)
        begin
            if (state_reg.task_us >= task_end)
            begin
                state_next.task_us   = 10'h000;
                state_next.task_tick = 1'b1;
                state_next.adj       = ADJ_NONE;
            end
            else
            begin
                state_next.task_us = state_reg.task_us + 10'h001;
            end
        end

        // late sync lengthens the task, early sync shortens it
        // set after the wrap so a coincident event is not lost
        if (sel_evt)
        begin
            if (state_reg.task_us > state_reg.cfg.ofs)
                state_next.adj = ADJ_LONG;
            else if (state_reg.task_us < state_reg.cfg.ofs)
                state_next.adj = ADJ_SHORT;
            else
                state_next.adj = ADJ_NONE;
        end

        // collect RxPDO data, release on SYNC
        if (can_rxpdo_valid_in)
        begin
            state_next.pdo_hold = can_rxpdo_data_in;
            state_next.pdo_pend = 1'b1;
        end
        // SYNC arrives as a decoded pulse, payload unused
        if (can_sync_in && (state_reg.pdo_pend || can_rxpdo_valid_in))
        begin
            state_next.pdo_app  = can_rxpdo_valid_in ? can_rxpdo_data_in : state_reg.pdo_hold;
            state_next.pdo_upd  = 1'b1;
            state_next.pdo_pend = 1'b0;
        end

        if (fault_perm_in.statemachine && cw_rise)
            state_next.fault_reset = 1'b1;
        if (fault_perm_in.key_allowed && key_rise)
            state_next.fault_reset = 1'b1;
        if ((fault_perm_in.din_allowed || fault_perm_in.din_hw) && din_rise)
            state_next.fault_reset = 1'b1;
    end

    // single register for block state; divider and monitors keep their own
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            state_reg         <= '0;
            state_reg.cfg.sel <= `TSS_SEL_RST;
            state_reg.cfg.ofs <= `TSS_OFS_RST_US;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // CANopen measurement and lock
    // lock per source
    tss_sync_monitor u_can_mon (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .us_tick_in  (us_tick),
        .event_in    (can_sync_in),
        .selected_in (state_reg.src == TSS_SRC_CAN),
        .task_pos_in (state_reg.task_us),
        .offset_in   (state_reg.cfg.ofs),
        .meas_out    (can_meas)
    );

    // secondary bus measurement and lock
    tss_sync_monitor u_sys_mon (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .us_tick_in  (us_tick),
        .event_in    (sys_evt),
        .selected_in (state_reg.src == TSS_SRC_SYS),
        .task_pos_in (state_reg.task_us),
        .offset_in   (state_reg.cfg.ofs),
        .meas_out    (sys_meas)
    );

    // readbacks straight from registers, except the two live activity qualifiers
    assign cfg_out                = state_reg.cfg;
    assign sync_source_in_use_out = state_reg.src;
    assign can_active_out         = can_act;   // live qualifier, not registered
    assign sys_active_out         = sys_act;
    assign can_meas_out           = can_meas;
    assign sys_meas_out           = sys_meas;
    assign task_tick_out          = state_reg.task_tick;
    assign task_pos_us_out        = state_reg.task_us;
    assign app_data_out           = state_reg.pdo_app;
    assign app_update_out         = state_reg.pdo_upd;
    assign fault_reset_out        = state_reg.fault_reset;

endmodule : tss_task_sync

/* tb/tss_task_sync_chk.sv */
`include "tss_params.svh"

module tss_task_sync_chk (
    input wire logic                  core_clk_in,
    input wire logic                  srst_in,
    input wire logic                  cfg_load_in,
    input wire tss_pkg::tss_cfg_s     cfg_in,
    input wire logic [6:0]            can_node_num_in,
    input wire logic                  can_sync_pdo_run_in,
    input wire logic                  can_sync_in,
    input wire logic                  can_rxpdo_valid_in,
    input wire logic [63:0]           can_rxpdo_data_in,
    input wire logic [6:0]            sys_node_id_in,
    input wire tss_pkg::tss_sysmode_e sys_sync_mode_in,
    input wire logic [15:0]           control_word_in,
    input wire tss_pkg::tss_fperm_s   fault_perm_in,
    input wire logic                  key_stop_in,
    input wire logic                  din_reset_in,
    input wire tss_pkg::tss_cfg_s     cfg_out,
    input wire tss_pkg::tss_src_e     sync_source_in_use_out,
    input wire logic                  can_active_out,
    input wire logic                  sys_active_out,
    input wire logic [63:0]           app_data_out,
    input wire logic                  app_update_out,
    input wire logic                  fault_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import tss_pkg::*;

    logic [2:0] prev_reg;
    logic       rise_any;
    logic       sel_ok;
    logic [9:0] ofs_clamp;

    // previous levels of the three reset sources, tracked whatever the permission
    always_ff @(posedge core_clk_in)
    begin
        prev_reg <= {control_word_in[`TSS_FR_CW_BIT], key_stop_in, din_reset_in};
    end

    // permitted rising edges, legal selector codes and the clamped offset
    always_comb
    begin
        rise_any = (control_word_in[`TSS_FR_CW_BIT] & ~prev_reg[2] & fault_perm_in.statemachine)
                 | (key_stop_in & ~prev_reg[1] & fault_perm_in.key_allowed)
                 | (din_reset_in & ~prev_reg[0] & (fault_perm_in.din_allowed | fault_perm_in.din_hw));
        sel_ok = cfg_in.sel inside {`TSS_SEL_AUTO, `TSS_SEL_CAN, `TSS_SEL_SYS, `TSS_SEL_OFF};
        ofs_clamp = (cfg_in.ofs < `TSS_OFS_MIN_US) ? `TSS_OFS_MIN_US :
                    (cfg_in.ofs > `TSS_OFS_MAX_US) ? `TSS_OFS_MAX_US : cfg_in.ofs;
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);

    cfg_keep_a:
        assert property (cfg_load_in && !sel_ok |=> $stable(cfg_out.sel))
        else $error("unknown selector code changed the selection");
    cfg_take_a:
        assert property (cfg_load_in && sel_ok |=> cfg_out.sel == $past(cfg_in.sel))
        else $error("legal selector code not taken");
    ofs_clamp_a:
        assert property (cfg_load_in |=> cfg_out.ofs == $past(ofs_clamp))
        else $error("phase offset not clamped to its range");
    auto_pick_a:
        assert property (cfg_out.sel == `TSS_SEL_AUTO |=> sync_source_in_use_out ==
            ($past(can_active_out) ? TSS_SRC_CAN : ($past(sys_active_out) ? TSS_SRC_SYS : TSS_SRC_NONE)))
        else $error("automatic choice picked the wrong source");
    fixed_pick_a:
        assert property (cfg_out.sel == `TSS_SEL_SYS |=> sync_source_in_use_out == TSS_SRC_SYS)
        else $error("fixed secondary selection not in effect");
    can_act_a:
        assert property (can_active_out == (can_node_num_in != `TSS_NODE_NONE && can_sync_pdo_run_in))
        else $error("fieldbus activity qualifier wrong");
    sys_act_a:
        assert property (sys_active_out == (sys_node_id_in != `TSS_NODE_NONE &&
            sys_sync_mode_in inside {TSS_SYS_SYNC, TSS_SYS_RXPDO}))
        else $error("secondary bus activity qualifier wrong");
    fr_rise_a:
        assert property (rise_any |=> fault_reset_out)
        else $error("permitted reset edge gave no pulse");
    fr_cause_a:
        assert property (fault_reset_out |-> $past(rise_any))
        else $error("fault reset pulse without permitted edge");
    pdo_sync_a:
        assert property (can_rxpdo_valid_in && can_sync_in |=> app_update_out && app_data_out == $past(can_rxpdo_data_in))
        else $error("data arriving with sync not transferred");
    upd_cause_a:
        assert property (app_update_out |-> $past(can_sync_in))
        else $error("application data changed without sync");

    cover property (fault_reset_out);
    cover property (app_update_out);
    cover property (sync_source_in_use_out == TSS_SRC_SYS);
endmodule : tss_task_sync_chk

bind tss_task_sync tss_task_sync_chk chk_u (.*);

/* tb/tss_master_model.sv */
module tss_master_model (
    input  wire logic        core_clk_in,
    input  wire logic        send_sync_in,
    input  wire logic        send_pdo_in,
    input  wire logic [63:0] pdo_data_in,
    output logic             sync_out,
    output logic             pdo_valid_out,
    output logic [63:0]      pdo_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sync_out      = 1'b0;
        pdo_valid_out = 1'b0;
        pdo_data_out  = '1;
    end

    // sync is a bare one-cycle pulse, no payload
    always @(posedge core_clk_in)
    begin
        sync_out      <= send_sync_in;
        pdo_valid_out <= send_pdo_in;
        // idle data toggles so a stale word never passes as fresh
        pdo_data_out  <= send_pdo_in ? pdo_data_in : ~pdo_data_out;
    end
endmodule : tss_master_model

/* tb/tss_task_sync_test.sv */
module tss_task_sync_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tss_pkg::*;

    typedef struct packed {
        logic [6:0] sel;
        logic [9:0] ofs;
        logic       cn;
        logic       run;
        logic       sn;
        logic [1:0] sm;
        logic [1:0] src;
        logic [9:0] ofs_exp;
        logic [1:0] acts;
    } tss_row_s;

    // selection, activity and offset cases; the last carries a refused code
    localparam tss_row_s ROWS [9] = '{
        '{7'h00, 10'h320, 1'b1, 1'b1, 1'b1, 2'h1, 2'h1, 10'h320, 2'h3},
        '{7'h00, 10'h28A, 1'b1, 1'b1, 1'b0, 2'h1, 2'h1, 10'h2BC, 2'h2},
        '{7'h00, 10'h3B6, 1'b0, 1'b1, 1'b1, 2'h2, 2'h3, 10'h384, 2'h1},
        '{7'h00, 10'h2BC, 1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 10'h2BC, 2'h0},
        '{7'h00, 10'h384, 1'b0, 1'b1, 1'b0, 2'h1, 2'h0, 10'h384, 2'h0},
        '{7'h02, 10'h2BD, 1'b0, 1'b0, 1'b0, 2'h0, 2'h3, 10'h2BD, 2'h0},
        '{7'h63, 10'h383, 1'b1, 1'b1, 1'b1, 2'h1, 2'h0, 10'h383, 2'h3},
        '{7'h01, 10'h320, 1'b0, 1'b0, 1'b0, 2'h0, 2'h1, 10'h320, 2'h0},
        '{7'h07, 10'h000, 1'b0, 1'b0, 1'b1, 2'h1, 2'h1, 10'h2BC, 2'h1}};
    // {levels cw key din, perms sm key din hw, expected pulse}
    localparam logic [7:0] FR [16] = '{8'h91, 8'h90, 8'h10, 8'h80, 8'h90, 8'h00, 8'h49, 8'h08,
        8'h40, 8'h00, 8'h25, 8'h00, 8'h23, 8'h00, 8'h88, 8'h38};

    logic                core_clk_in, srst_in, cfg_load_in;
    tss_cfg_s            cfg_in, cfg_out;
    logic [6:0]          can_node_num_in, sys_node_id_in;
    logic                can_sync_pdo_run_in, can_sync_in, can_rxpdo_valid_in;
    logic [63:0]         can_rxpdo_data_in, app_data_out, pdo_word;
    tss_sysmode_e        sys_sync_mode_in;
    logic                sys_sync_in, sys_rxpdo_in, key_stop_in, din_reset_in;
    logic [15:0]         control_word_in;
    tss_fperm_s          fault_perm_in;
    tss_src_e            sync_source_in_use_out;
    logic                can_active_out, sys_active_out, task_tick_out;
    tss_meas_s           can_meas_out, sys_meas_out;
    logic [9:0]          task_pos_us_out, pos_first;
    logic                app_update_out, fault_reset_out, send_sync, send_pdo, seen;
    int                  failures, check_count;

    tss_task_sync dut_u (.*);

    tss_master_model master_u (
        .core_clk_in   (core_clk_in),
        .send_sync_in  (send_sync),
        .send_pdo_in   (send_pdo),
        .pdo_data_in   (pdo_word),
        .sync_out      (can_sync_in),
        .pdo_valid_out (can_rxpdo_valid_in),
        .pdo_data_out  (can_rxpdo_data_in)
    );

    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task automatic chk_v(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_v

    task automatic chk_b(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_b

    // reset, then the factory selection and offset must stand
    task automatic do_reset;
        @(posedge core_clk_in);
        srst_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(negedge core_clk_in);
        chk_v(cfg_out, {7'h01, 10'h320});
        chk_b(fault_reset_out, 1'b0);
        repeat (2) @(negedge core_clk_in);
        chk_v(sync_source_in_use_out, TSS_SRC_CAN);
    endtask : do_reset

    // master request, then a bounded watch for the application update
    task automatic pdo_step(input logic s, input logic p, input logic [63:0] d, input logic up,
                            input logic [63:0] exp);
        @(posedge core_clk_in);
        send_sync <= s;
        send_pdo <= p;
        pdo_word <= d;
        @(posedge core_clk_in);
        send_sync <= 1'b0;
        send_pdo <= 1'b0;
        seen = 1'b0;
        repeat (6)
        begin
            @(negedge core_clk_in);
            if (app_update_out === 1'b1)
                seen = 1'b1;
        end
        chk_b(seen, up);
        chk_v(app_data_out, exp);
    endtask : pdo_step

    // secondary sync driven with the master sync request; CAN pulse lands a clock later, each one cycle
    task automatic both_sync;
        @(posedge core_clk_in);
        send_sync <= 1'b1;
        sys_sync_in <= 1'b1;
        sys_rxpdo_in <= 1'b1;
        @(posedge core_clk_in);
        send_sync <= 1'b0;
        sys_sync_in <= 1'b0;
        sys_rxpdo_in <= 1'b0;
    endtask : both_sync

    initial
    begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    // guard against a hang anywhere in the sequence
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        failures++;
        wrap_up();
    end

    initial
    begin
        {srst_in, cfg_load_in, can_sync_pdo_run_in, sys_sync_in, sys_rxpdo_in} = '0;
        {key_stop_in, din_reset_in, send_sync, send_pdo} = '0;
        {cfg_in, can_node_num_in, sys_node_id_in, control_word_in, fault_perm_in, pdo_word} = '0;
        sys_sync_mode_in = TSS_SYS_OFF;
        failures = 0;
        check_count = 0;
        do_reset();
        foreach (ROWS[i])
        begin
            @(posedge core_clk_in);
            cfg_load_in <= 1'b1;
            cfg_in <= '{ROWS[i].sel, ROWS[i].ofs};
            can_node_num_in <= ROWS[i].cn ? 7'h05 : 7'h00;
            can_sync_pdo_run_in <= ROWS[i].run;
            sys_node_id_in <= ROWS[i].sn ? 7'h03 : 7'h00;
            sys_sync_mode_in <= tss_sysmode_e'(ROWS[i].sm);
            @(posedge core_clk_in);
            cfg_load_in <= 1'b0;
            repeat (3) @(negedge core_clk_in);
            chk_v(cfg_out.ofs, ROWS[i].ofs_exp);
            chk_v(sync_source_in_use_out, ROWS[i].src);
            chk_v({can_active_out, sys_active_out}, ROWS[i].acts);
        end
        do_reset();
        foreach (FR[i])
        begin
            @(posedge core_clk_in);
            control_word_in <= {8'h00, FR[i][7], 7'h00};
            {key_stop_in, din_reset_in} <= FR[i][6:5];
            fault_perm_in <= FR[i][4:1];
            @(posedge core_clk_in);
            @(negedge core_clk_in);
            chk_b(fault_reset_out, FR[i][0]);
            @(negedge core_clk_in);
            chk_b(fault_reset_out, 1'b0);
        end
        pdo_step(1'b0, 1'b1, 64'h0123_4567_89AB_CDEF, 1'b0, 64'h0000_0000_0000_0000);
        pdo_step(1'b1, 1'b0, 64'h0000_0000_0000_0000, 1'b1, 64'h0123_4567_89AB_CDEF);
        pdo_step(1'b1, 1'b0, 64'h0000_0000_0000_0000, 1'b0, 64'h0123_4567_89AB_CDEF);
        pdo_step(1'b1, 1'b1, 64'hFEDC_BA98_7654_3210, 1'b1, 64'hFEDC_BA98_7654_3210);
        pdo_step(1'b0, 1'b1, 64'h1111_2222_3333_4444, 1'b0, 64'hFEDC_BA98_7654_3210);
        pdo_step(1'b0, 1'b1, 64'h5555_6666_7777_8888, 1'b0, 64'hFEDC_BA98_7654_3210);
        pdo_step(1'b1, 1'b0, 64'h0000_0000_0000_0000, 1'b1, 64'h5555_6666_7777_8888);
        // two syncs exactly 4000 clocks, that is 20 us, apart
        sys_sync_mode_in <= TSS_SYS_SYNC;
        both_sync();
        repeat (10) @(negedge core_clk_in);
        pos_first = can_meas_out.pos_us;
        repeat (3989) @(posedge core_clk_in);
        both_sync();
        repeat (10) @(negedge core_clk_in);
        chk_v(can_meas_out.period_us, 16'h0014);
        chk_v(sys_meas_out.period_us, 16'h0014);
        chk_v(can_meas_out.pos_us - pos_first, 10'h014);
        wrap_up();
    end
endmodule : tss_task_sync_test
